// >>> pmrs_pkg.sv
// pmrs_pkg.sv: shared constants, mode codes and sequencer state type
// assumes a 10 MHz system clock and a separate slow tick input
`default_nettype none
package pmrs_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned SLOW_HZ = 32768;
  // watchdog times, seconds
  localparam int unsigned WDOG_IRQ_S = 2;
  localparam int unsigned WDOG_RST_S = 4;
  localparam int unsigned WDOG_IRQ_TICKS = WDOG_IRQ_S * SLOW_HZ;
  localparam int unsigned WDOG_RST_TICKS = WDOG_RST_S * SLOW_HZ;
  // regulator settle time, microseconds
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W = 24;
  localparam logic [2:0] MODE_W_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_W_IDLE = 3'h1;
  localparam logic [2:0] MODE_W_SLEEP = 3'h2;
  localparam logic [2:0] MODE_W_PDS = 3'h3;
  localparam logic [2:0] MODE_W_EXTENDED_POWER_DOWN_SLEEP = 3'h4;
  localparam logic [2:0] MODE_W_OFF = 3'h5;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_TIMER = 2'h1;
  localparam logic [1:0] CAUSE_GPIO = 2'h2;
  typedef enum logic [7:0] {
    SEQ_RESET = 8'h01,
    SEQ_BUCK = 8'h02,
    SEQ_LDO = 8'h04,
    SEQ_ACTIVE = 8'h08,
    SEQ_IDLE = 8'h10,
    SEQ_SLEEP = 8'h20,
    SEQ_LOWPWR = 8'h40,
    SEQ_OFF = 8'h80
  } pmrs_seq_t;
endpackage
`default_nettype wire

// >>> pmrs_sync.sv
// pmrs_sync.sv: two flip-flop level synchroniser
// assumes input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pmrs_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level in and out
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> pmrs_sequencer.sv
// pmrs_sequencer.sv: power-on order, low-power modes, wake, watchdog
// assumes firmware strobes on the same clock; pins and slow tick async
`timescale 1ns/1ps
`default_nettype none
module pmrs_sequencer #(
  parameter int unsigned SETTLE_CYCLES = pmrs_pkg::SETTLE_CYC,
  parameter int unsigned WDOG_IRQ_TICKS = pmrs_pkg::WDOG_IRQ_TICKS,
  parameter int unsigned WDOG_RST_TICKS = pmrs_pkg::WDOG_RST_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // supply and pins
  input wire logic batteryGood,
  input wire logic extResetPin_n,
  input wire logic brownout,
  input wire logic regStable,
  input wire logic slowTickIn,
  input wire logic gpioWake,
  // firmware command
  input wire logic modeReq,
  input wire logic [2:0] modeSel,
  input wire logic wdogKick,
  input wire logic wakeInterval,
  // power and clock controls
  output logic buckEn,
  output logic ldoEn,
  output logic ldoLowVolt,
  output logic coreReset_n,
  output logic coreHalt,
  output logic fastClkEn,
  output logic fastClkSlow,
  output logic periphClkEn,
  output logic slowClkEn,
  output logic radioPwr,
  output logic corePwr,
  output logic ramPwr,
  output logic alwaysOnPwr,
  // status
  output logic wdogIrq,
  output logic offExitFlag,
  output logic [1:0] wakeCause,
  output logic [2:0] modeNow
);
  localparam int unsigned CNT_W = pmrs_pkg::CNT_W;
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic batSync, rstSync_n, boSync, stabSync, tickSync, gpioSync, tickDly_r, tickPulse;
  pmrs_sync #(.RESET_VAL(1'b0)) uBat (.clk(clk), .reset_n(reset_n), .asyncIn(batteryGood),
    .syncOut(batSync));
  pmrs_sync #(.RESET_VAL(1'b0)) uRst (.clk(clk), .reset_n(reset_n), .asyncIn(extResetPin_n),
    .syncOut(rstSync_n));
  pmrs_sync #(.RESET_VAL(1'b0)) uBo (.clk(clk), .reset_n(reset_n), .asyncIn(brownout),
    .syncOut(boSync));
  pmrs_sync #(.RESET_VAL(1'b0)) uStab (.clk(clk), .reset_n(reset_n), .asyncIn(regStable),
    .syncOut(stabSync));
  pmrs_sync #(.RESET_VAL(1'b0)) uTick (.clk(clk), .reset_n(reset_n), .asyncIn(slowTickIn),
    .syncOut(tickSync));
  pmrs_sync #(.RESET_VAL(1'b0)) uGpio (.clk(clk), .reset_n(reset_n), .asyncIn(gpioWake),
    .syncOut(gpioSync));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tickDly_r <= 1'b0;
    end else begin
      tickDly_r <= tickSync;
    end
  end
  assign tickPulse = tickSync & ~tickDly_r;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  pmrs_pkg::pmrs_seq_t seq_r;
  logic [pmrs_pkg::CNT_W-1:0] settle_r;
  logic [pmrs_pkg::CNT_W-1:0] wdog_r;
  logic wdogBite;
  logic supplyBad;
  logic wakeHit, timerHit, lowPwr;
  assign supplyBad = !batSync || !rstSync_n || boSync || wdogBite;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_r <= pmrs_pkg::SEQ_RESET;
      settle_r <= '0;
    end else if (supplyBad) begin
      seq_r <= pmrs_pkg::SEQ_RESET;
      settle_r <= '0;
    end else begin
      case (seq_r)
        pmrs_pkg::SEQ_RESET: begin
          seq_r <= pmrs_pkg::SEQ_BUCK;
          settle_r <= '0;
        end
        pmrs_pkg::SEQ_BUCK: begin
          if (settle_r == CNT_W'(SETTLE_CYCLES - 1)) begin
            seq_r <= pmrs_pkg::SEQ_LDO;
            settle_r <= '0;
          end else begin
            settle_r <= settle_r + 1'b1;
          end
        end
        pmrs_pkg::SEQ_LDO: begin
          if (settle_r < CNT_W'(SETTLE_CYCLES - 1)) begin
            settle_r <= settle_r + 1'b1;
          end else if (stabSync) begin
            seq_r <= pmrs_pkg::SEQ_ACTIVE;
          end
        end
        pmrs_pkg::SEQ_ACTIVE, pmrs_pkg::SEQ_IDLE: begin
          if (modeReq) begin
            case (modeSel)
              pmrs_pkg::MODE_W_ACTIVE: seq_r <= pmrs_pkg::SEQ_ACTIVE;
              pmrs_pkg::MODE_W_IDLE: seq_r <= pmrs_pkg::SEQ_IDLE;
              pmrs_pkg::MODE_W_SLEEP: seq_r <= pmrs_pkg::SEQ_SLEEP;
              pmrs_pkg::MODE_W_PDS, pmrs_pkg::MODE_W_EXTENDED_POWER_DOWN_SLEEP: seq_r <= pmrs_pkg::SEQ_LOWPWR;
              pmrs_pkg::MODE_W_OFF: seq_r <= pmrs_pkg::SEQ_OFF;
              default: seq_r <= seq_r;
            endcase
          end
        end
        pmrs_pkg::SEQ_SLEEP, pmrs_pkg::SEQ_LOWPWR: begin
          if (wakeHit) begin
            seq_r <= pmrs_pkg::SEQ_ACTIVE;
          end
        end
        pmrs_pkg::SEQ_OFF: begin
          if (wakeHit) begin
            seq_r <= pmrs_pkg::SEQ_RESET;
          end
        end
        default: seq_r <= pmrs_pkg::SEQ_RESET;
      endcase
    end
  end

  // ----------------------------------------
  // low-power mode register and wake timer
  // ----------------------------------------
  logic [2:0] mode_r;
  logic [pmrs_pkg::CNT_W-1:0] wakeCnt_r;
  logic [pmrs_pkg::CNT_W-1:0] wakeLoad_r;
  assign lowPwr = (seq_r == pmrs_pkg::SEQ_SLEEP) || (seq_r == pmrs_pkg::SEQ_LOWPWR) ||
    (seq_r == pmrs_pkg::SEQ_OFF);
  assign timerHit = lowPwr && (wakeLoad_r != '0) && (wakeCnt_r >= wakeLoad_r);
  assign wakeHit = timerHit || (lowPwr && gpioSync);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_r <= pmrs_pkg::MODE_W_ACTIVE;
      wakeLoad_r <= '0;
    end else if (supplyBad || seq_r == pmrs_pkg::SEQ_RESET) begin
      mode_r <= pmrs_pkg::MODE_W_ACTIVE;
    end else if (modeReq && (seq_r == pmrs_pkg::SEQ_ACTIVE || seq_r == pmrs_pkg::SEQ_IDLE) &&
      modeSel <= pmrs_pkg::MODE_W_OFF) begin
      mode_r <= modeSel;
      wakeLoad_r <= wakeInterval ? CNT_W'(WDOG_IRQ_TICKS) : '0;
    end else if (wakeHit && seq_r != pmrs_pkg::SEQ_OFF) begin
      mode_r <= pmrs_pkg::MODE_W_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wakeCnt_r <= '0;
    end else if (!lowPwr) begin
      wakeCnt_r <= '0;
    end else if (tickPulse || seq_r == pmrs_pkg::SEQ_OFF) begin
      // deep off has no slow clock, so the fast timebase measures time
      wakeCnt_r <= wakeCnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // deep off exit record, survives core reset
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      offExitFlag <= 1'b0;
      wakeCause <= pmrs_pkg::CAUSE_NONE;
    end else if (wakeHit) begin
      offExitFlag <= (seq_r == pmrs_pkg::SEQ_OFF);
      wakeCause <= gpioSync ? pmrs_pkg::CAUSE_GPIO : pmrs_pkg::CAUSE_TIMER;
    end
  end

  // ----------------------------------------
  // watchdog on the slow tick
  // ----------------------------------------
  assign wdogBite = (wdog_r >= CNT_W'(WDOG_RST_TICKS));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wdog_r <= '0;
    end else if (wdogKick || seq_r != pmrs_pkg::SEQ_ACTIVE && seq_r != pmrs_pkg::SEQ_IDLE) begin
      wdog_r <= '0;
    end else if (tickPulse) begin
      wdog_r <= wdog_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wdogIrq <= 1'b0;
    end else begin
      wdogIrq <= (wdog_r >= CNT_W'(WDOG_IRQ_TICKS));
    end
  end

  // ----------------------------------------
  // domain and clock controls
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      buckEn <= 1'b0;
      ldoEn <= 1'b0;
      ldoLowVolt <= 1'b0;
      coreReset_n <= 1'b0;
      coreHalt <= 1'b0;
      fastClkEn <= 1'b0;
      fastClkSlow <= 1'b0;
      periphClkEn <= 1'b0;
      slowClkEn <= 1'b0;
      radioPwr <= 1'b0;
      corePwr <= 1'b0;
      ramPwr <= 1'b0;
      alwaysOnPwr <= 1'b0;
      modeNow <= pmrs_pkg::MODE_W_ACTIVE;
    end else begin
      buckEn <= seq_r != pmrs_pkg::SEQ_RESET && seq_r != pmrs_pkg::SEQ_OFF;
      ldoEn <= !(seq_r inside {pmrs_pkg::SEQ_RESET, pmrs_pkg::SEQ_BUCK, pmrs_pkg::SEQ_OFF});
      ldoLowVolt <= seq_r inside {pmrs_pkg::SEQ_SLEEP, pmrs_pkg::SEQ_LOWPWR};
      coreReset_n <= seq_r inside {pmrs_pkg::SEQ_ACTIVE, pmrs_pkg::SEQ_IDLE,
        pmrs_pkg::SEQ_SLEEP, pmrs_pkg::SEQ_LOWPWR};
      coreHalt <= seq_r inside {pmrs_pkg::SEQ_IDLE, pmrs_pkg::SEQ_SLEEP,
        pmrs_pkg::SEQ_LOWPWR};
      fastClkEn <= seq_r inside {pmrs_pkg::SEQ_ACTIVE, pmrs_pkg::SEQ_IDLE};
      fastClkSlow <= seq_r == pmrs_pkg::SEQ_IDLE;
      periphClkEn <= seq_r inside {pmrs_pkg::SEQ_ACTIVE, pmrs_pkg::SEQ_IDLE};
      slowClkEn <= seq_r != pmrs_pkg::SEQ_RESET && seq_r != pmrs_pkg::SEQ_OFF;
      radioPwr <= seq_r inside {pmrs_pkg::SEQ_ACTIVE, pmrs_pkg::SEQ_IDLE,
        pmrs_pkg::SEQ_SLEEP};
      corePwr <= seq_r inside {pmrs_pkg::SEQ_ACTIVE, pmrs_pkg::SEQ_IDLE, pmrs_pkg::SEQ_SLEEP} ||
        (seq_r == pmrs_pkg::SEQ_LOWPWR && mode_r == pmrs_pkg::MODE_W_PDS);
      ramPwr <= seq_r != pmrs_pkg::SEQ_OFF && seq_r != pmrs_pkg::SEQ_RESET;
      alwaysOnPwr <= 1'b1;
      modeNow <= mode_r;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_off_powerdown: assert property (@(posedge clk) disable iff (!reset_n)
    seq_r == pmrs_pkg::SEQ_OFF |=> !buckEn && !corePwr && !slowClkEn && alwaysOnPwr)
    else $error("deep off left a domain powered");
  a_buck_first: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(ldoEn) |-> buckEn)
    else $error("regulators enabled before buck");
  a_core_release: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(coreReset_n) |-> ldoEn && $past(stabSync))
    else $error("core released before regulators stable");
  a_ext_reset: assert property (@(posedge clk) disable iff (!reset_n)
    !rstSync_n |-> ##2 !coreReset_n)
    else $error("external reset not obeyed");
  a_brownout_off: assert property (@(posedge clk) disable iff (!reset_n)
    boSync |=> seq_r == pmrs_pkg::SEQ_RESET)
    else $error("brownout did not shut down");
  a_idle_clocks: assert property (@(posedge clk) disable iff (!reset_n)
    seq_r == pmrs_pkg::SEQ_IDLE |=> coreHalt && fastClkSlow && periphClkEn)
    else $error("idle clocks wrong");
  a_sleep_clocks: assert property (@(posedge clk) disable iff (!reset_n)
    seq_r == pmrs_pkg::SEQ_SLEEP |=> !fastClkEn && slowClkEn && ldoLowVolt)
    else $error("sleep clocks wrong");
  a_wdog_irq: assert property (@(posedge clk) disable iff (!reset_n)
    wdog_r == CNT_W'(WDOG_IRQ_TICKS) |=> wdogIrq)
    else $error("watchdog interrupt missing");
  a_wdog_reset: assert property (@(posedge clk) disable iff (!reset_n)
    wdogBite |=> seq_r == pmrs_pkg::SEQ_RESET)
    else $error("watchdog reset missing");
  a_active_full: assert property (@(posedge clk) disable iff (!reset_n)
    seq_r == pmrs_pkg::SEQ_ACTIVE |=> fastClkEn && !fastClkSlow && !coreHalt)
    else $error("active mode not at full speed");
  a_off_record: assert property (@(posedge clk) disable iff (!reset_n)
    seq_r == pmrs_pkg::SEQ_OFF && wakeHit |=> offExitFlag && wakeCause != pmrs_pkg::CAUSE_NONE)
    else $error("deep off exit not recorded");
endmodule
`default_nettype wire

// >>> pmrs_fw_model.sv
// pmrs_fw_model.sv: firmware and external reset driver model
// assumes the bench asks for each command one clock ahead
`timescale 1ns/1ps
`default_nettype none
module pmrs_fw_model (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic goReq,
  input wire logic [2:0] goMode,
  input wire logic goTimer,
  input wire logic kickOn,
  input wire logic rstReq,
  // design status
  input wire logic coreReset_n,
  // design commands
  output logic modeReq,
  output logic [2:0] modeSel,
  output logic wakeInterval,
  output logic wdogKick,
  output logic extResetPin_n
);
  logic [5:0] kickCnt_r;
  initial begin
    modeReq = 1'b0;
    modeSel = 3'h0;
    wakeInterval = 1'b0;
    wdogKick = 1'b0;
    extResetPin_n = 1'b1;
    kickCnt_r = 6'h00;
    forever begin
      @(posedge clk);
      // one strobe per command, only with the core running
      modeReq <= goReq && coreReset_n;
      modeSel <= goReq ? goMode : ~modeSel;
      wakeInterval <= goReq ? goTimer : ~wakeInterval;
      // periodic restart
      kickCnt_r <= kickCnt_r + 6'h01;
      wdogKick <= kickOn && (kickCnt_r == 6'h3F);
      // reset pin, any time
      extResetPin_n <= ~rstReq;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the power sequencer
// assumes shortened settle and watchdog counts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, reset_n, batteryGood, brownout, regStable, slowTickIn, gpioWake;
  logic goReq, goTimer, kickOn, rstReq, modeReq, wakeInterval, wdogKick, extResetPin_n;
  logic [2:0] goMode, modeSel, modeNow;
  logic buckEn, ldoEn, ldoLowVolt, coreReset_n, coreHalt, fastClkEn, fastClkSlow;
  logic periphClkEn, slowClkEn, radioPwr, corePwr, ramPwr, alwaysOnPwr, wdogIrq, offExitFlag;
  logic [1:0] wakeCause;
  int bad_count, num_checks, n;
  pmrs_sequencer #(.SETTLE_CYCLES(4), .WDOG_IRQ_TICKS(8), .WDOG_RST_TICKS(16)) dut_u (
    .clk(clk), .reset_n(reset_n), .batteryGood(batteryGood), .extResetPin_n(extResetPin_n),
    .brownout(brownout), .regStable(regStable), .slowTickIn(slowTickIn), .gpioWake(gpioWake),
    .modeReq(modeReq), .modeSel(modeSel), .wdogKick(wdogKick), .wakeInterval(wakeInterval),
    .buckEn(buckEn), .ldoEn(ldoEn), .ldoLowVolt(ldoLowVolt), .coreReset_n(coreReset_n),
    .coreHalt(coreHalt), .fastClkEn(fastClkEn), .fastClkSlow(fastClkSlow),
    .periphClkEn(periphClkEn), .slowClkEn(slowClkEn), .radioPwr(radioPwr), .corePwr(corePwr),
    .ramPwr(ramPwr), .alwaysOnPwr(alwaysOnPwr), .wdogIrq(wdogIrq), .offExitFlag(offExitFlag),
    .wakeCause(wakeCause), .modeNow(modeNow));
  pmrs_fw_model fw_u (
    .clk(clk), .goReq(goReq), .goMode(goMode), .goTimer(goTimer), .kickOn(kickOn),
    .rstReq(rstReq), .coreReset_n(coreReset_n), .modeReq(modeReq), .modeSel(modeSel),
    .wakeInterval(wakeInterval), .wdogKick(wdogKick), .extResetPin_n(extResetPin_n));
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    slowTickIn = 1'b0;
    #7001;
    forever #15259 slowTickIn = ~slowTickIn;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic cmd(input logic [2:0] m, input logic t);
    @(posedge clk);
    goReq <= 1'b1;
    goMode <= m;
    goTimer <= t;
    @(posedge clk);
    goReq <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_core;
    for (n = 0; n < 200 && coreReset_n !== 1'b1; n++) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup;
    for (n = 0; n < 100 && buckEn !== 1'b1; n++) @(posedge clk);
    chk(ldoEn, 1'b0, "regulators before buck");
    for (n = 0; n < 100 && ldoEn !== 1'b1; n++) @(posedge clk);
    chk(buckEn, 1'b1, "buck dropped");
    repeat (20) @(posedge clk);
    chk(coreReset_n, 1'b0, "core released early");
    regStable <= 1'b1;
    wait_core();
    chk(coreReset_n, 1'b1, "core not released");
    repeat (2) @(posedge clk);
    chk({periphClkEn, fastClkEn, coreHalt}, 3'h6, "active clocks");
  endtask
  task automatic t_idle;
    cmd(3'h1, 1'b0);
    chk({coreHalt, fastClkSlow, slowClkEn}, 3'h7, "idle outputs");
    chk(modeNow, 3'h1, "idle mode");
    cmd(3'h0, 1'b0);
    chk({coreHalt, fastClkSlow, fastClkEn}, 3'h1, "back to active");
    cmd(3'h7, 1'b0);
    chk(modeNow, 3'h0, "reserved mode taken");
    chk(fastClkEn, 3'h1, "reserved mode left active");
  endtask
  task automatic t_lowpwr;
    for (int m = 2; m <= 4; m++) begin
      cmd(m[2:0], 1'b0);
      chk(modeNow, m[2:0], "low power mode");
      chk({fastClkEn, ramPwr}, 3'h1, "fast clock or ram");
      if (m == 2) chk({slowClkEn, ldoLowVolt, coreHalt}, 3'h7, "sleep outputs");
      if (m == 2) chk(periphClkEn, 3'h0, "peripheral clock in sleep");
      if (m == 3) chk(corePwr, 3'h1, "core logic lost in power-down");
      if (m > 2) chk(radioPwr, 1'b0, "radio powered");
      if (m == 4) chk(corePwr, 1'b0, "core powered");
      gpioWake <= 1'b1;
      for (n = 0; n < 20 && fastClkEn !== 1'b1; n++) @(posedge clk);
      gpioWake <= 1'b0;
      repeat (2) @(posedge clk);
      chk({fastClkEn, wakeCause}, 3'h6, "gpio wake");
    end
    cmd(3'h2, 1'b1);
    for (n = 0; n < 4000 && fastClkEn !== 1'b1; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk({fastClkEn, wakeCause}, 3'h5, "timer wake");
  endtask
  task automatic t_off;
    cmd(3'h5, 1'b0);
    chk({corePwr, radioPwr, buckEn}, 3'h0, "off supplies");
    chk({ldoEn, slowClkEn, alwaysOnPwr}, 3'h1, "off domain");
    gpioWake <= 1'b1;
    for (n = 0; n < 20 && buckEn !== 1'b1; n++) @(posedge clk);
    gpioWake <= 1'b0;
    chk(coreReset_n, 1'b0, "no full init");
    wait_core();
    chk({coreReset_n, offExitFlag}, 3'h3, "off exit flag");
    chk(wakeCause, 2'h2, "off wake cause");
  endtask
  task automatic t_wdog;
    repeat (3000) @(posedge clk);
    chk(wdogIrq, 1'b0, "irq while kicked");
    kickOn <= 1'b0;
    for (n = 0; n < 4000 && wdogIrq !== 1'b1; n++) @(posedge clk);
    chk({wdogIrq, coreReset_n}, 3'h3, "watchdog irq");
    for (n = 0; n < 4000 && coreReset_n !== 1'b0; n++) @(posedge clk);
    chk(coreReset_n, 1'b0, "watchdog reset");
    kickOn <= 1'b1;
    wait_core();
    chk(coreReset_n, 3'h1, "no restart after watchdog");
  endtask
  task automatic t_resets;
    rstReq <= 1'b1;
    repeat (8) @(posedge clk);
    chk(coreReset_n, 1'b0, "pin reset ignored");
    rstReq <= 1'b0;
    wait_core();
    chk(coreReset_n, 1'b1, "no restart");
    brownout <= 1'b1;
    repeat (8) @(posedge clk);
    chk(coreReset_n, 1'b0, "brownout ignored");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {reset_n, brownout, regStable, gpioWake, goReq, goTimer, rstReq} = 7'h00;
    goMode = 3'h0;
    bad_count = 0;
    num_checks = 0;
    batteryGood = 1'b1;
    kickOn = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_powerup();
    t_idle();
    t_lowpwr();
    t_off();
    t_wdog();
    t_resets();
    final_report();
  end
  initial begin
    #4000000;
    $display("[FAIL] %0t watchdog timeout", $time);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
